/* File: hw/irc_top.sv */
// ------------------------------------------------------------------
// Receive FIFO
// ------------------------------------------------------------------
//
// Our own choice: the APB interface to the registers.
module irc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  // Refuse depths that the wrap-bit pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_depth_bad
    $error("irc_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words
  logic [AW:0] wr_q; // Write pointer with wrap bit
  logic [AW:0] rd_q; // Read pointer with wrap bit
  logic push; // Word accepted
  logic pop; // Word drained

  assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule : irc_fifo

module irc_top
  import irc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = IRC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lowpower_enter,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] pgate_q; // Power gate register
  irc_ctrl1_t ctrl1_q; // Control register 1
  logic mst_q; // Master select control bit
  logic mode_q; // Interface mode enable
  logic soft_reset_field_arm_q; // First soft reset code seen
  irc_oaddr_t oaddr_q; // Own address register
  logic [7:0] txbuf_q; // Write side of data buffer
  logic pin_q; // Service idle flag
  logic aas_q; // Addressed as target
  logic gc_q; // General call seen
  logic trx_q; // Transmit direction from address
  logic lrb_q; // Last received bit
  logic bb_q; // Bus busy
  logic [31:0] prdata_q; // Read data
  logic pready_q; // Access ready
  logic pslverr_q; // Unmapped access
  logic scl_s1, scl_s2, scl_s3; // Clock pin sync and history
  logic sda_s1, sda_s2, sda_s3; // Data pin sync and history
  irc_link_t link_q; // Link state
  logic [3:0] cnt_q; // Clocks seen in frame
  logic [7:0] rxsh_q; // Receive shifter
  logic [7:0] txsh_q; // Transmit shifter
  logic sda_oe_q; // Data pin pull-down
  logic scl_oe_q; // Clock pin stretch

  // ----------------------------------------------------------------
  // Decoded terms
  // ----------------------------------------------------------------
  logic gate; // Interface clock gate on
  logic link_on; // Link logic active
  logic setup; // APB setup cycle
  logic wr; // Write takes effect
  logic rd; // Read completes
  logic wr_gate; // Write to gated registers
  logic soft_reset_field_fire; // Soft reset pulse
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [3:0] nbits; // Data bits in frame
  logic [3:0] flen; // Clocks in frame
  logic [7:0] rx_next; // Shifter after this edge
  logic byte_done; // Frame ends on this edge
  logic hit_now; // Address in shifter matches
  logic hit_done; // Address at frame end matches
  logic rx_valid, rx_ready; // FIFO handshake
  logic [7:0] rx_head; // FIFO head byte
  logic push; // Receive byte into FIFO
  logic addr_ok; // Mapped address
  logic [7:0] rmux; // Read mux
  irc_status_t status; // Status image

  assign gate = pgate_q[IRC_GATE_BIT];
  assign link_on = gate & mode_q;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_q & pwrite;
  assign rd = psel & penable & pready_q & ~pwrite;
  assign wr_gate = wr & gate;
  assign soft_reset_field_fire = wr_gate & mode_q & (paddr == IRC_ADDR_CTRL2) & soft_reset_field_arm_q
    & (pwdata[1:0] == IRC_SOFT_RESET_FIELD_FIRE);
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  assign nbits = (link_q == IRC_LS_ADDR || ctrl1_q.bit_count_field == 3'h0) ? IRC_FULL_BYTE
    : {1'b0, ctrl1_q.bit_count_field};
  assign flen = nbits + {3'h0, ctrl1_q.ack_enable};
  assign rx_next = (cnt_q < nbits) ? {rxsh_q[6:0], sda_s2} : rxsh_q;
  assign byte_done = link_on & scl_rise & (cnt_q == flen - 4'h1)
    & (link_q == IRC_LS_ADDR || link_q == IRC_LS_DATA);
  // Zero own address also answers start byte 0x01 through this compare
  assign hit_now = ~ctrl1_q.address_detect_disable
    & (rxsh_q[7:1] == oaddr_q.own_slave_address || rxsh_q == IRC_GENERAL_CALL);
  assign hit_done = ~ctrl1_q.address_detect_disable
    & (rx_next[7:1] == oaddr_q.own_slave_address || rx_next == IRC_GENERAL_CALL);
  assign push = byte_done & (link_q == IRC_LS_DATA) & ~trx_q;
  assign status = '{mst_q, trx_q, bb_q, pin_q, 1'b0, aas_q, gc_q, lrb_q};

  // Open-drain pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Address decode and read mux
  always_comb
  begin
    addr_ok = 1'b1;
    rmux = 8'h00;
    if (paddr == IRC_ADDR_PGATE)
      rmux = pgate_q;
    else if (paddr == IRC_ADDR_CTRL1)
      rmux = ctrl1_q;
    else if (paddr == IRC_ADDR_CTRL2)
      rmux = status;
    else if (paddr == IRC_ADDR_OADDR)
      rmux = oaddr_q;
    else if (paddr == IRC_ADDR_DBUF)
      rmux = rx_valid ? rx_head : 8'h00;
    else
      addr_ok = 1'b0;
  end

  // Answer registered in setup, ready in first access cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= {24'h00_0000, rmux};
        pslverr_q <= ~addr_ok;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Power gate, never gated itself
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pgate_q <= IRC_PGATE_RST;
    else if (wr && paddr == IRC_ADDR_PGATE)
      pgate_q <= pwdata[7:0];
  end

  // Control register 1
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl1_q <= IRC_CTRL1_RST;
    else if (lowpower_enter || soft_reset_field_fire)
      ctrl1_q <= IRC_CTRL1_RST;
    else if (wr_gate && paddr == IRC_ADDR_CTRL1)
      ctrl1_q <= pwdata[7:0];
    else if (link_on && start_det)
      ctrl1_q.bit_count_field <= 3'h0;
  end

  // Own address register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      oaddr_q <= IRC_OADDR_RST;
    else if (lowpower_enter || soft_reset_field_fire)
      oaddr_q <= IRC_OADDR_RST;
    else if (wr_gate && paddr == IRC_ADDR_OADDR)
      oaddr_q <= pwdata[7:0];
  end

  // Control register 2: mode bit writable whenever the gate is on, rest only in mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= 1'b0;
      mst_q <= 1'b0;
      soft_reset_field_arm_q <= 1'b0;
    end
    else
    begin
      if (wr_gate && paddr == IRC_ADDR_CTRL2)
        mode_q <= pwdata[3];
      // Mode off also clears the master bit that status shows
      if (lowpower_enter || soft_reset_field_fire || !mode_q)
      begin
        mst_q <= 1'b0;
        soft_reset_field_arm_q <= 1'b0;
      end
      else if (wr_gate && mode_q && paddr == IRC_ADDR_CTRL2)
      begin
        mst_q <= pwdata[7];
        soft_reset_field_arm_q <= (pwdata[1:0] == IRC_SOFT_RESET_FIELD_ARM);
      end
    end
  end

  // Data buffer write side
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      txbuf_q <= IRC_DBUF_RST;
    else if (lowpower_enter)
      txbuf_q <= IRC_DBUF_RST;
    else if (wr_gate && paddr == IRC_ADDR_DBUF)
      txbuf_q <= pwdata[7:0];
  end

  // Service flag: frame end wins over a release in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_q <= 1'b1;
    else if (!mode_q || soft_reset_field_fire)
      pin_q <= 1'b1;
    else if (byte_done)
      pin_q <= 1'b0;
    else if (wr_gate && paddr == IRC_ADDR_DBUF)
      pin_q <= 1'b1;
    else if (wr_gate && paddr == IRC_ADDR_CTRL2 && pwdata[4])
      pin_q <= 1'b1;
  end

  // Status flags from the link
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aas_q <= 1'b0;
      gc_q <= 1'b0;
      trx_q <= 1'b0;
      lrb_q <= 1'b0;
      bb_q <= 1'b0;
    end
    else if (!mode_q || soft_reset_field_fire || !gate)
    begin
      aas_q <= 1'b0;
      gc_q <= 1'b0;
      trx_q <= 1'b0;
      lrb_q <= 1'b0;
      bb_q <= 1'b0;
    end
    else
    begin
      if (start_det)
        bb_q <= 1'b1;
      else if (stop_det)
        bb_q <= 1'b0;
      if (scl_rise)
        lrb_q <= sda_s2;
      if (start_det || stop_det)
      begin
        aas_q <= 1'b0;
        gc_q <= 1'b0;
        trx_q <= 1'b0;
      end
      else if (byte_done && link_q == IRC_LS_ADDR)
      begin
        aas_q <= hit_done;
        gc_q <= hit_done & (rx_next == IRC_GENERAL_CALL);
        trx_q <= hit_done & rx_next[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  // Pin synchronisers plus one history stage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end
    else
    begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
    end
  end

  // Frame tracking and receive shifter
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_q <= IRC_LS_IDLE;
      cnt_q <= 4'h0;
      rxsh_q <= 8'h00;
    end
    else if (!link_on || lowpower_enter || soft_reset_field_fire)
      link_q <= IRC_LS_IDLE;
    else if (start_det)
    begin
      link_q <= IRC_LS_ADDR;
      cnt_q <= 4'h0;
    end
    else if (stop_det)
      link_q <= IRC_LS_IDLE;
    else if (scl_rise && link_q != IRC_LS_IDLE)
    begin
      rxsh_q <= rx_next;
      cnt_q <= byte_done ? 4'h0 : cnt_q + 4'h1;
      if (byte_done && link_q == IRC_LS_ADDR)
        link_q <= hit_done ? IRC_LS_DATA : IRC_LS_SKIP;
    end
  end

  // Acknowledge and transmit drive, changed on clock falls
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_oe_q <= 1'b0;
      txsh_q <= 8'h00;
    end
    else if (!link_on || link_q == IRC_LS_IDLE || link_q == IRC_LS_SKIP)
      sda_oe_q <= 1'b0;
    else
    begin
      if (byte_done)
        txsh_q <= txbuf_q;
      else if (scl_fall)
      begin
        if (ctrl1_q.ack_enable && cnt_q == nbits)
          sda_oe_q <= (link_q == IRC_LS_ADDR) ? hit_now : ~trx_q;
        else if (link_q == IRC_LS_DATA && trx_q && cnt_q < nbits)
        begin
          sda_oe_q <= ~txsh_q[7];
          txsh_q <= {txsh_q[6:0], 1'b0};
        end
        else
          sda_oe_q <= 1'b0;
      end
    end
  end

  // Stretch clock while service pending or FIFO full
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      scl_oe_q <= 1'b0;
    else
      scl_oe_q <= link_on & (link_q == IRC_LS_DATA) & ~scl_s2 & (~pin_q | ~rx_ready);
  end

  // Read side of data buffer
  irc_fifo #(
    .WIDTH(IRC_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .flush(lowpower_enter),
    .in_valid(push),
    .in_ready(rx_ready),
    .in_data(rx_next),
    .out_valid(rx_valid),
    .out_ready(rd && paddr == IRC_ADDR_DBUF),
    .out_data(rx_head)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  gate_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !gate |=> link_q == IRC_LS_IDLE && !sda_oe_q) else $error("link active with gate off");
  gate_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    !gate && wr && !lowpower_enter |=> $stable(ctrl1_q) && $stable(oaddr_q) && $stable(txbuf_q))
    else $error("gated write took effect");
  mode_lock_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr && !mode_q && !lowpower_enter |=> $stable(mst_q)) else $error("locked field written");
  status_init_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mode_q |=> status == IRC_STATUS_RST) else $error("status not initialized");
  soft_init_a: assert property (@(posedge clk) disable iff (!arst_n)
    soft_reset_field_fire |=> ctrl1_q == IRC_CTRL1_RST && oaddr_q == IRC_OADDR_RST && pin_q)
    else $error("soft reset missed");
  lp_init_a: assert property (@(posedge clk) disable iff (!arst_n)
    lowpower_enter |=> ctrl1_q == IRC_CTRL1_RST && txbuf_q == IRC_DBUF_RST && !rx_valid
    && oaddr_q == IRC_OADDR_RST)
    else $error("low-power init missed");
  zero_match_a: assert property (@(posedge clk) disable iff (!arst_n)
    byte_done && link_q == IRC_LS_ADDR && oaddr_q.own_slave_address == 7'h00
    && rx_next == 8'h01 && !ctrl1_q.address_detect_disable && !start_det && !stop_det
    |=> link_q == IRC_LS_DATA) else $error("start byte not matched");
  dbuf_split_a: assert property (@(posedge clk) disable iff (!arst_n)
    setup && paddr == IRC_ADDR_DBUF && !rx_valid |=> prdata_q == 32'h0000_0000)
    else $error("written data read back");
  msb_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    link_on && scl_fall && !byte_done && link_q == IRC_LS_DATA && trx_q && cnt_q < nbits
    && !(ctrl1_q.ack_enable && cnt_q == nbits) |=> sda_oe_q == !$past(txsh_q[7]))
    else $error("transmit bit order wrong");
  shared_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    setup && paddr == IRC_ADDR_CTRL2 ##1 pready_q |-> prdata_q[7:0] == $past(status))
    else $error("control 2 read not status");
  ready_a: assert property (@(posedge clk) disable iff (!arst_n)
    setup |=> pready_q ##1 !pready_q || setup) else $error("apb answer timing");

  match_c: cover property (@(posedge clk) disable iff (!arst_n)
    byte_done && link_q == IRC_LS_ADDR && hit_done);
  fifo_full_c: cover property (@(posedge clk) disable iff (!arst_n) !rx_ready);
  soft_reset_c: cover property (@(posedge clk) disable iff (!arst_n) soft_reset_field_fire);
  tx_byte_c: cover property (@(posedge clk) disable iff (!arst_n) byte_done && trx_q);
endmodule : irc_top

/* File: shared/irc_pkg.sv */
package irc_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IRC_IDX_CTRL1 = 12'h022;
  localparam logic [11:0] IRC_IDX_CTRL2 = 12'h023;
  localparam logic [11:0] IRC_IDX_OADDR = 12'h024;
  localparam logic [11:0] IRC_IDX_DBUF = 12'h025;
  localparam logic [11:0] IRC_IDX_PGATE = 12'hf75;
  localparam logic [15:0] IRC_ADDR_CTRL1 = {2'h0, IRC_IDX_CTRL1, 2'h0};
  localparam logic [15:0] IRC_ADDR_CTRL2 = {2'h0, IRC_IDX_CTRL2, 2'h0};
  localparam logic [15:0] IRC_ADDR_OADDR = {2'h0, IRC_IDX_OADDR, 2'h0};
  localparam logic [15:0] IRC_ADDR_DBUF = {2'h0, IRC_IDX_DBUF, 2'h0};
  localparam logic [15:0] IRC_ADDR_PGATE = {2'h0, IRC_IDX_PGATE, 2'h0};

  // ----------------------------------------------------------------
  // Field positions, reset values and codes
  // ----------------------------------------------------------------
  localparam int unsigned IRC_GATE_BIT = 4;
  localparam logic [7:0] IRC_PGATE_RST = 8'h00;
  localparam logic [7:0] IRC_CTRL1_RST = 8'h00;
  localparam logic [7:0] IRC_OADDR_RST = 8'h00;
  localparam logic [7:0] IRC_DBUF_RST = 8'h00;
  localparam logic [7:0] IRC_STATUS_RST = 8'h10;
  localparam logic [1:0] IRC_SOFT_RESET_FIELD_ARM = 2'h2;
  localparam logic [1:0] IRC_SOFT_RESET_FIELD_FIRE = 2'h1;
  localparam logic [7:0] IRC_GENERAL_CALL = 8'h00;
  localparam logic [3:0] IRC_FULL_BYTE = 4'h8;
  localparam int unsigned IRC_FIFO_DEPTH = 32;
  localparam int unsigned IRC_DATA_W = 8;

  // Control register 1 layout
  typedef struct packed {
    logic [2:0] bit_count_field;
    logic ack_enable;
    logic address_detect_disable;
    logic [2:0] clock_select;
  } irc_ctrl1_t;

  // Control register 2 layout (write side)
  typedef struct packed {
    logic master_select;
    logic transmit_direction;
    logic bus_busy_flag;
    logic service_release;
    logic interface_mode_enable;
    logic spare;
    logic [1:0] soft_reset_field;
  } irc_ctrl2_t;

  // Status register 2 layout (read side)
  typedef struct packed {
    logic master_select;
    logic transmit_direction;
    logic bus_busy_flag;
    logic service_idle;
    logic arbitration_lost;
    logic addressed_as_target;
    logic general_call_seen;
    logic last_received_bit;
  } irc_status_t;

  // Own address layout
  typedef struct packed {
    logic [6:0] own_slave_address;
    logic address_format_select;
  } irc_oaddr_t;

  // Slave link states
  typedef enum logic [1:0] {
    IRC_LS_IDLE = 2'b00,
    IRC_LS_ADDR = 2'b01,
    IRC_LS_DATA = 2'b10,
    IRC_LS_SKIP = 2'b11
  } irc_link_t;

endpackage : irc_pkg

/* File: verif/irc_bus_master.sv */
// ------------------------------------------------------------------
// Bus master model: open-drain, pull-ups make a released line high
// ------------------------------------------------------------------
module irc_bus_master
(
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic stuck
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half of the 160 ns link period, in 8 ns cycles
  localparam int HALF = 10;

  // Both lines released and no hang seen at time zero
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck = 1'b0;
  end

  // Idle wait on the system clock
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause

  // Release SCL and wait, bounded, while the target stretches it
  task automatic rise();
    int n;
    n = 0;
    scl_low <= 1'b0;
    pause(2);
    while (scl !== 1'b1 && n < 4000)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 4000)
      stuck <= 1'b1;
    pause(HALF);
  endtask : rise

  // One clock: data set while SCL low, sampled while SCL high
  task automatic clk_bit(input logic b, output logic r);
    sda_low <= ~b;
    pause(HALF);
    rise();
    r = sda;
    scl_low <= 1'b1;
  endtask : clk_bit

  // Eight clocks, most significant bit first
  task automatic clk_byte(input logic [7:0] tx, output logic [7:0] rx);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(tx[i], b);
      rx = {rx[6:0], b};
    end
  endtask : clk_byte

  // SDA falls while SCL is high; the clock then stands low
  task automatic start();
    sda_low <= 1'b1;
    pause(HALF);
    scl_low <= 1'b1;
    pause(HALF);
  endtask : start

  // SDA rises while SCL is high; both lines then stand high
  task automatic stop();
    sda_low <= 1'b1;
    pause(HALF);
    rise();
    sda_low <= 1'b0;
    pause(HALF);
  endtask : stop
endmodule : irc_bus_master

/* File: verif/test_i2c_register_control.sv */
module test_i2c_register_control
  import irc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, lowpower_enter;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic scl_oe, sda_oe, m_scl_low, m_sda_low, m_stuck, serr, ack;
  logic scl_o, sda_o;
  logic [7:0] rdv, rx;
  int n_errors, cmp_count;
  // Wired-AND lines with pull-ups
  wire scl = ~(scl_oe | m_scl_low);
  wire sda = ~(sda_oe | m_sda_low);

  irc_top #(.FIFO_DEPTH(4)) dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lowpower_enter(lowpower_enter), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));

  irc_bus_master m_u (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low), .stuck(m_stuck));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // APB master: setup, access held until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int w;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    w = 0;
    while (pready !== 1'b1)
    begin
      w++;
      @(posedge clk);
    end
    chk("wait states", 8'(w), 8'h00);
    rdv = prdata[7:0];
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] m,
    input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(name, rdv & m, exp);
  endtask : rd_chk

  // One address frame, then release and stop
  task automatic frame(input logic [7:0] own, input logic [7:0] a, input logic gate,
    input logic exp);
    wr(IRC_ADDR_OADDR, own);
    wr(IRC_ADDR_DBUF, 8'hff);
    wr(IRC_ADDR_PGATE, {3'h0, gate, 4'h0});
    m_u.start();
    m_u.clk_byte(a, rx);
    m_u.clk_bit(1'b1, ack);
    chk("address ack", {7'h00, ack}, {7'h00, exp});
    wr(IRC_ADDR_DBUF, 8'h00);
    m_u.stop();
    wr(IRC_ADDR_PGATE, 8'h10);
  endtask : frame

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #400000;
    n_errors++;
    $display("mismatch watchdog expected end seen hang");
    results();
  end

  initial
  begin
    {arst_n, psel, penable, pwrite, lowpower_enter} = '0;
    paddr = '0;
    pwdata = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk("gate reset", IRC_ADDR_PGATE, 8'hff, 8'h00);
    chk("pin drive level", {6'h00, scl_o, sda_o}, 8'h00);
    rd_chk("status reset", IRC_ADDR_CTRL2, 8'hfe, 8'h10);
    wr(IRC_ADDR_CTRL1, 8'h5c);
    rd_chk("ctrl1 gated", IRC_ADDR_CTRL1, 8'hff, 8'h00);
    wr(IRC_ADDR_OADDR, 8'h5c);
    rd_chk("oaddr gated", IRC_ADDR_OADDR, 8'hff, 8'h00);
    apb(1'b0, 16'h0100, 8'h00);
    chk("unmapped", {7'h00, serr}, 8'h01);
    $display("test reset and gate done");
    wr(IRC_ADDR_PGATE, 8'h10);
    rd_chk("gate on", IRC_ADDR_PGATE, 8'hff, 8'h10);
    wr(IRC_ADDR_CTRL2, 8'h80);
    wr(IRC_ADDR_CTRL2, 8'h08);
    rd_chk("mst locked", IRC_ADDR_CTRL2, 8'h80, 8'h00);
    wr(IRC_ADDR_CTRL2, 8'h88);
    rd_chk("mst set", IRC_ADDR_CTRL2, 8'h80, 8'h80);
    wr(IRC_ADDR_CTRL1, 8'h13);
    wr(IRC_ADDR_OADDR, 8'ha4);
    rd_chk("ctrl1 rw", IRC_ADDR_CTRL1, 8'hff, 8'h13);
    wr(IRC_ADDR_CTRL2, 8'h8a);
    wr(IRC_ADDR_CTRL2, 8'h89);
    rd_chk("sw ctrl1", IRC_ADDR_CTRL1, 8'hff, 8'h00);
    rd_chk("sw oaddr", IRC_ADDR_OADDR, 8'hff, 8'h00);
    rd_chk("sw status", IRC_ADDR_CTRL2, 8'hfe, 8'h10);
    wr(IRC_ADDR_CTRL2, 8'h88);
    rd_chk("mode kept", IRC_ADDR_CTRL2, 8'h80, 8'h80);
    wr(IRC_ADDR_CTRL2, 8'h00);
    rd_chk("mode off", IRC_ADDR_CTRL2, 8'hfe, 8'h10);
    wr(IRC_ADDR_CTRL2, 8'h08);
    wr(IRC_ADDR_CTRL1, 8'h13);
    wr(IRC_ADDR_OADDR, 8'ha4);
    lowpower_enter <= 1'b1;
    @(posedge clk);
    lowpower_enter <= 1'b0;
    @(posedge clk);
    rd_chk("lp ctrl1", IRC_ADDR_CTRL1, 8'hff, 8'h00);
    rd_chk("lp oaddr", IRC_ADDR_OADDR, 8'hff, 8'h00);
    $display("test registers done");
    // Receive four bytes into a four-deep FIFO, then stall on full
    wr(IRC_ADDR_CTRL1, 8'h13);
    wr(IRC_ADDR_OADDR, 8'ha4);
    m_u.start();
    m_u.clk_byte(8'ha4, rx);
    m_u.clk_bit(1'b1, ack);
    chk("rx ack", {7'h00, ack}, 8'h00);
    rd_chk("addressed", IRC_ADDR_CTRL2, 8'h54, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      wr(IRC_ADDR_DBUF, 8'h00);
      m_u.clk_byte(8'h10 + 8'(i), rx);
      m_u.clk_bit(1'b1, ack);
    end
    wr(IRC_ADDR_DBUF, 8'h00);
    repeat (20) @(posedge clk);
    chk("full stall", {7'h00, scl_oe}, 8'h01);
    for (int i = 0; i < 4; i++)
      rd_chk("rx data", IRC_ADDR_DBUF, 8'hff, 8'h10 + 8'(i));
    rd_chk("rx empty", IRC_ADDR_DBUF, 8'hff, 8'h00);
    m_u.stop();
    $display("test receive done");
    // Transmit one byte to a reading master
    wr(IRC_ADDR_DBUF, 8'hc3);
    m_u.start();
    m_u.clk_byte(8'ha5, rx);
    m_u.clk_bit(1'b1, ack);
    chk("tx ack", {7'h00, ack}, 8'h00);
    rd_chk("tx dir", IRC_ADDR_CTRL2, 8'h40, 8'h40);
    wr(IRC_ADDR_DBUF, 8'hc3);
    m_u.clk_byte(8'hff, rx);
    chk("tx byte", rx, 8'hc3);
    m_u.clk_bit(1'b1, ack);
    wr(IRC_ADDR_DBUF, 8'hff);
    m_u.stop();
    $display("test transmit done");
    frame(8'h00, 8'h01, 1'b1, 1'b0);
    frame(8'ha4, 8'h30, 1'b1, 1'b1);
    frame(8'ha4, 8'ha4, 1'b0, 1'b1);
    frame(8'ha4, 8'h00, 1'b1, 1'b0);
    wr(IRC_ADDR_CTRL1, 8'h1b);
    frame(8'ha4, 8'ha4, 1'b1, 1'b1);
    chk("link hang", {7'h00, m_stuck}, 8'h00);
    $display("test address frames done");
    results();
  end
endmodule : test_i2c_register_control
